// File: hw/seq_pkg.sv
package seq_pkg;
   // Instruction class presented by the decoder
   typedef enum logic [3:0] {
      CLS_SHORT,      // One word, 8-bit immediate or registers
      CLS_IMM16,      // 16-bit immediate
      CLS_IMM32,      // 32-bit immediate
      CLS_TWO_WORD,   // Two-word encoding (long logic, and-into-control)
      CLS_BTST_SHORT, // Bit test, register indirect or 8-bit absolute
      CLS_BTST_ABS16,
      CLS_BTST_ABS32,
      CLS_BRANCH8,
      CLS_BRANCH16,
      CLS_BIT_CLEAR_OP_REG,
      CLS_BIT_CLEAR_OP_SHORT, // Bit clear, register indirect or 8-bit absolute
      CLS_BIT_CLEAR_OP_ABS16,
      CLS_BIT_CLEAR_OP_ABS32
   } instr_class_t;

   // Target of one bus cycle
   typedef enum logic [2:0] {
      TGT_SECOND, TGT_THIRD, TGT_FOURTH, TGT_FIFTH,
      TGT_NEXT, TGT_OPERAND, TGT_VECTOR, TGT_NONE
   } target_t;

   // One slot of the cycle list
   typedef struct packed {
      logic    write;
      logic    word;
      logic    lock;
      logic    internal;
      target_t target;
   } slot_t;

   localparam int MAX_SLOTS        = 9;
   localparam int SLOT_IDX_W       = 4;
   localparam int ADDR_W           = 24;
   localparam logic [ADDR_W-1:0] WORD_STRIDE = 24'h000002;
   localparam int INTERNAL_CYCLES  = 1;
endpackage

// File: hw/slot_list_if.sv
`timescale 1ns/1ps
// Carries the decoded cycle list from the lookup to the sequencer
interface slot_list_if;
   import seq_pkg::*;
   instr_class_t cls;
   slot_t        slots [MAX_SLOTS];
   logic [3:0]   count;
   modport table_side (input cls, output slots, output count);
   modport seq_side   (output cls, input slots, input count);
endinterface

// File: hw/cycle_list_table.sv
`timescale 1ns/1ps
// Constant lookup from instruction class to its ordered cycle list
module cycle_list_table
   import seq_pkg::*;
(
   slot_list_if.table_side lst
);
   function automatic slot_t mk(input logic w, input logic wd, input logic lk,
                                input target_t t);
      mk = '{write: w, word: wd, lock: lk, internal: 1'b0, target: t};
   endfunction

   localparam slot_t RW2   = '{1'b0, 1'b1, 1'b0, 1'b0, TGT_SECOND};
   localparam slot_t RW3   = '{1'b0, 1'b1, 1'b0, 1'b0, TGT_THIRD};
   localparam slot_t RW4   = '{1'b0, 1'b1, 1'b0, 1'b0, TGT_FOURTH};
   localparam slot_t RWN   = '{1'b0, 1'b1, 1'b0, 1'b0, TGT_NEXT};
   localparam slot_t RWNM  = '{1'b0, 1'b1, 1'b1, 1'b0, TGT_NEXT};
   localparam slot_t RBE   = '{1'b0, 1'b0, 1'b0, 1'b0, TGT_OPERAND};
   localparam slot_t RBEM  = '{1'b0, 1'b0, 1'b1, 1'b0, TGT_OPERAND};
   localparam slot_t WBE   = '{1'b1, 1'b0, 1'b0, 1'b0, TGT_OPERAND};
   localparam slot_t RWE   = '{1'b0, 1'b1, 1'b0, 1'b0, TGT_OPERAND};
   localparam slot_t IDLE  = '{1'b0, 1'b0, 1'b0, 1'b1, TGT_NONE};

   // Unused slots hold IDLE; count bounds the walk
   always_comb begin
      for (int i = 0; i < MAX_SLOTS; i++) begin
         lst.slots[i] = IDLE;
      end
      lst.count = 4'h1;
      case (lst.cls)
         CLS_SHORT, CLS_BIT_CLEAR_OP_REG: begin
            lst.slots[0] = RWN;
         end
         CLS_IMM16, CLS_TWO_WORD: begin
            lst.slots[0] = RW2;
            lst.slots[1] = RWN;
            lst.count    = 4'h2;
         end
         CLS_IMM32: begin
            lst.slots[0] = RW2;
            lst.slots[1] = RW3;
            lst.slots[2] = RWN;
            lst.count    = 4'h3;
         end
         CLS_BTST_SHORT: begin
            lst.slots[0] = RW2;
            lst.slots[1] = RBE;
            lst.slots[2] = RWNM;
            lst.count    = 4'h3;
         end
         CLS_BTST_ABS16: begin
            lst.slots[0] = RW2;
            lst.slots[1] = RW3;
            lst.slots[2] = RBE;
            lst.slots[3] = RWNM;
            lst.count    = 4'h4;
         end
         CLS_BTST_ABS32: begin
            lst.slots[0] = RW2;
            lst.slots[1] = RW3;
            lst.slots[2] = RW4;
            lst.slots[3] = RBE;
            lst.slots[4] = RWNM;
            lst.count    = 4'h5;
         end
         CLS_BRANCH8: begin
            lst.slots[0] = RWN;
            lst.slots[1] = RWE;
            lst.count    = 4'h2;
         end
         CLS_BRANCH16: begin
            lst.slots[0] = RW2;
            lst.slots[1] = IDLE;
            lst.slots[2] = RWE;
            lst.count    = 4'h3;
         end
         CLS_BIT_CLEAR_OP_SHORT: begin
            lst.slots[0] = RW2;
            lst.slots[1] = RBEM;
            lst.slots[2] = RWNM;
            lst.slots[3] = WBE;
            lst.count    = 4'h4;
         end
         CLS_BIT_CLEAR_OP_ABS16: begin
            lst.slots[0] = RW2;
            lst.slots[1] = RW3;
            lst.slots[2] = RBEM;
            lst.slots[3] = RWNM;
            lst.slots[4] = WBE;
            lst.count    = 4'h5;
         end
         CLS_BIT_CLEAR_OP_ABS32: begin
            lst.slots[0] = RW2;
            lst.slots[1] = RW3;
            lst.slots[2] = RW4;
            lst.slots[3] = RBEM;
            lst.slots[4] = RWNM;
            lst.slots[5] = WBE;
            lst.count    = 4'h6;
         end
         default: begin
            lst.slots[0] = mk(1'b0, 1'b1, 1'b0, TGT_NEXT);
         end
      endcase
   end
endmodule

// File: hw/cpu_bus_cycle_sequencer.sv
`timescale 1ns/1ps
module cpu_bus_cycle_sequencer
   import seq_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              srst,
   input  wire logic              instr_valid,
   input  wire instr_class_t      instr_class,
   input  wire logic [ADDR_W-1:0] instr_addr,
   input  wire logic [ADDR_W-1:0] next_addr,
   input  wire logic [ADDR_W-1:0] operand_addr,
   input  wire logic              bus_ack,
   output logic                   instr_ready,
   output logic                   bus_req,
   output logic                   bus_write,
   output logic                   bus_word,
   output logic                   bus_lock,
   output logic [ADDR_W-1:0]      bus_addr,
   output target_t                bus_target,
   output logic                   instr_done
);
   typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_INTERNAL} state_t;

   state_t            state_q;
   instr_class_t      cls_q;
   logic [3:0]        idx_q;
   logic [ADDR_W-1:0] base_q;
   logic [ADDR_W-1:0] next_q;
   logic [ADDR_W-1:0] oper_q;
   slot_t             cur;
   logic [3:0]        int_cnt_q;
   logic              slot_over;
   logic              list_over;

   slot_list_if lst ();
   assign lst.cls = cls_q;

   cycle_list_table u_table (
      .lst (lst)
   );

   // Address of one slot; extension words step by a word from the opcode
   function automatic logic [ADDR_W-1:0] slot_addr(input target_t t);
      case (t)
         TGT_SECOND:  slot_addr = base_q + WORD_STRIDE;
         TGT_THIRD:   slot_addr = base_q + (WORD_STRIDE << 1);
         TGT_FOURTH:  slot_addr = base_q + 24'(WORD_STRIDE * 3);
         TGT_FIFTH:   slot_addr = base_q + (WORD_STRIDE << 2);
         TGT_NEXT:    slot_addr = next_q;
         TGT_OPERAND: slot_addr = oper_q;
         default:     slot_addr = '0;
      endcase
   endfunction

   assign cur = lst.slots[idx_q];

   // True when idx is the final slot; the cap keeps a bad count from running
   // past the nine-slot list
   function automatic logic is_last(input logic [3:0] idx, input logic [3:0] cnt);
      is_last = (idx + 4'h1 >= cnt) || (idx == 4'(MAX_SLOTS - 1));
   endfunction

   // A slot is over once its bus cycle is acknowledged or its internal
   // state has run its length
   function automatic logic slot_finished(input state_t     st,
                                          input logic       ack,
                                          input logic [3:0] spent);
      case (st)
         ST_WAIT:     slot_finished = ack;
         ST_INTERNAL: slot_finished = (spent + 4'h1 >= 4'(INTERNAL_CYCLES));
         default:     slot_finished = 1'b0;
      endcase
   endfunction

   // Acknowledge counts only in the wait state, so a stray pulse while
   // nothing is requested cannot skip a slot
   assign slot_over = slot_finished(state_q, bus_ack, int_cnt_q);
   assign list_over = slot_over && is_last(idx_q, lst.count);

   // Control state: issue a slot, then wait for its acknowledge or let
   // the internal state run out before moving on
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (instr_valid) begin
                  state_q <= ST_ISSUE;
               end
            end
            ST_ISSUE: begin
               // Table settles one cycle after the class is latched
               state_q <= cur.internal ? ST_INTERNAL : ST_WAIT;
            end
            ST_WAIT, ST_INTERNAL: begin
               if (list_over) begin
                  state_q <= ST_IDLE;
               end else if (slot_over) begin
                  state_q <= ST_ISSUE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Instruction context, captured once when the instruction is taken;
   // the caller may change its inputs freely afterwards
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cls_q  <= CLS_SHORT;
         base_q <= '0;
         next_q <= '0;
         oper_q <= '0;
      end else if (state_q == ST_IDLE && instr_valid) begin
         cls_q  <= instr_class;
         base_q <= instr_addr;
         next_q <= next_addr;
         oper_q <= operand_addr;
      end
   end

   // Slot index walks the list in order, never skipping or revisiting
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         idx_q <= 4'h0;
      end else if (state_q == ST_IDLE) begin
         idx_q <= 4'h0;
      end else if (slot_over && !list_over) begin
         idx_q <= idx_q + 4'h1;
      end
   end

   // Length of an internal state; cleared whenever the state is left
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         int_cnt_q <= 4'h0;
      end else if (state_q == ST_INTERNAL && !slot_over) begin
         int_cnt_q <= int_cnt_q + 4'h1;
      end else begin
         int_cnt_q <= 4'h0;
      end
   end

   // Ready drops on the taking edge and returns with the last slot, so a
   // new instruction cannot be taken while the list is still running
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         instr_ready <= 1'b1;
      end else if (state_q == ST_IDLE && instr_valid) begin
         instr_ready <= 1'b0;
      end else if (list_over) begin
         instr_ready <= 1'b1;
      end
   end

   // One-cycle completion pulse at the end of the list
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         instr_done <= 1'b0;
      end else begin
         instr_done <= list_over;
      end
   end

   // Request strobe; held until the acknowledge edge and dropped for at least one
   // cycle after it (three when an internal slot follows), so two cycles never merge into one long request
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         bus_req <= 1'b0;
      end else if (state_q == ST_ISSUE) begin
         bus_req <= ~cur.internal;
      end else if (state_q == ST_WAIT && bus_ack) begin
         bus_req <= 1'b0;
      end
   end

   // Cycle kind and lock, loaded at issue and left in place after the
   // acknowledge; the controller reads them only while the request stands
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         bus_write <= 1'b0;
         bus_word  <= 1'b0;
         bus_lock  <= 1'b0;
      end else if (state_q == ST_ISSUE) begin
         bus_write <= cur.write;
         bus_word  <= cur.word;
         bus_lock  <= cur.lock;
      end
   end

   // Address and target of the slot being issued
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         bus_addr   <= '0;
         bus_target <= TGT_NONE;
      end else if (state_q == ST_ISSUE) begin
         bus_addr   <= slot_addr(cur.target);
         bus_target <= cur.target;
      end
   end
endmodule

// File: test/seq_properties.sv
`timescale 1ns/1ps
// Port-level checks of the cycle sequencer
module seq_properties
   import seq_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              srst,
   input wire logic              instr_valid,
   input wire logic              instr_ready,
   input wire logic              bus_req,
   input wire logic              bus_ack,
   input wire logic              bus_write,
   input wire logic              bus_word,
   input wire logic              bus_lock,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire target_t           bus_target,
   input wire logic              instr_done
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   req_hold_a: assert property (bus_req && !bus_ack |=>
      bus_req && $stable({bus_write, bus_word, bus_lock, bus_addr})) else $error("request moved");
   ack_drop_a: assert property (bus_req && bus_ack |=> !bus_req)
      else $error("request held after ack");
   take_lat_a: assert property (instr_valid && instr_ready |=> !bus_req ##1 bus_req)
      else $error("first request not on time");
   busy_ready_a: assert property (bus_req |-> !instr_ready)
      else $error("ready during request");
   done_pulse_a: assert property (instr_done |-> !bus_req ##1 !instr_done)
      else $error("done not a clean pulse");
   write_byte_a: assert property (bus_req && bus_write |->
      !bus_word && !bus_lock && bus_target == TGT_OPERAND) else $error("bad write cycle");
   lock_read_a: assert property (bus_req && bus_lock |->
      !bus_write && (bus_target == TGT_NEXT || !bus_word)) else $error("lock on wrong cycle");
   next_gap_a: assert property (bus_req && bus_ack |-> ##[1:4] (bus_req || instr_done))
      else $error("sequence stalled");
   word_even_a: assert property (bus_req && bus_word && bus_target != TGT_OPERAND |->
      !bus_addr[0]) else $error("odd word address");

   cover property (bus_req && bus_write);
   cover property (bus_req && bus_lock && bus_ack);
   cover property (instr_done);
endmodule

bind cpu_bus_cycle_sequencer seq_properties u_props (.sys_clk, .srst, .instr_valid,
   .instr_ready, .bus_req, .bus_ack, .bus_write, .bus_word, .bus_lock, .bus_addr,
   .bus_target, .instr_done);

// File: test/bus_ctrl_model.sv
`timescale 1ns/1ps
// Bus controller stand-in with a settable number of wait cycles
module bus_ctrl_model (
   input  wire logic       sys_clk,
   input  wire logic       srst,
   input  wire logic       bus_req,
   input  wire logic       bus_lock,
   input  wire logic [3:0] wait_cycles,
   output logic            bus_ack,
   output logic            held_q
);
   logic [3:0] cnt_q;

   // Single ack pulse per request; cleared at once so it is never taken twice
   always_ff @(posedge sys_clk) begin
      if (srst || bus_ack) begin
         bus_ack <= 1'b0;
         cnt_q   <= 4'h0;
      end else if (bus_req) begin
         if (cnt_q == wait_cycles) bus_ack <= 1'b1;
         else cnt_q <= cnt_q + 4'h1;
      end
   end

   // No grant to another master in the gap after a locked cycle
   always_ff @(posedge sys_clk) begin
      if (srst) held_q <= 1'b0;
      else if (bus_req && bus_ack) held_q <= bus_lock;
   end
endmodule

// File: test/cpu_bus_cycle_sequencer_test.sv
`timescale 1ns/1ps
module cpu_bus_cycle_sequencer_test
   import seq_pkg::*;
;
   localparam logic [5:0] RW2 = 6'h10, RW3 = 6'h11, RW4 = 6'h12, RWN = 6'h14, RWE = 6'h15;
   localparam logic [5:0] RBE = 6'h05, RBEM = 6'h0d, RWNM = 6'h1c, WBE = 6'h25;
   logic              sys_clk = 1'b0, srst = 1'b1, instr_valid = 1'b0;
   logic              bus_ack, instr_ready, bus_req, bus_write, bus_word, bus_lock, instr_done;
   logic              held;
   instr_class_t      cls = CLS_SHORT;
   logic [ADDR_W-1:0] ia = 24'h0, na = 24'h0, oa = 24'h0, bus_addr;
   target_t           bus_target;
   logic [3:0]        wt = 4'h0;
   int                err_count = 0, tests_run = 0;

   always #5 sys_clk = ~sys_clk;

   cpu_bus_cycle_sequencer u_dut (.sys_clk(sys_clk), .srst(srst), .instr_valid(instr_valid),
      .instr_class(cls), .instr_addr(ia), .next_addr(na), .operand_addr(oa),
      .bus_ack(bus_ack), .instr_ready(instr_ready), .bus_req(bus_req), .bus_write(bus_write),
      .bus_word(bus_word), .bus_lock(bus_lock), .bus_addr(bus_addr),
      .bus_target(bus_target), .instr_done(instr_done));

   bus_ctrl_model u_bus (.sys_clk(sys_clk), .srst(srst), .bus_req(bus_req),
      .bus_lock(bus_lock), .wait_cycles(wt), .bus_ack(bus_ack), .held_q(held));

   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task finish_test;
      $display("Checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Address each target should carry, from the offered instruction
   function logic [23:0] addr_of(input target_t t);
      case (t)
         TGT_SECOND: addr_of = ia + 24'h2;
         TGT_THIRD:  addr_of = ia + 24'h4;
         TGT_FOURTH: addr_of = ia + 24'h6;
         TGT_NEXT:   addr_of = na;
         default:    addr_of = oa;
      endcase
   endfunction

   // Offer one instruction, then match every acked cycle against the list e
   task run(input instr_class_t c, input int n, input logic [35:0] e, input logic [3:0] w);
      logic [5:0] s;
      int         k;
      k = 0;
      for (int i = 0; i < 20 && instr_ready !== 1'b1; i++) @(negedge sys_clk);
      if (instr_ready !== 1'b1) begin
         err_count++;
         finish_test();
      end
      cls = c;
      wt = w;
      ia = {12'h100, 7'h0, c, 1'b0};
      na = ia + 24'h00000a;
      oa = {12'h0ff, 8'h00, c};
      instr_valid = 1'b1;
      @(negedge sys_clk);
      instr_valid = 1'b0;
      for (int i = 0; i < 200 && instr_done !== 1'b1; i++) begin
         @(negedge sys_clk);
         if (bus_req === 1'b1 && bus_ack === 1'b1) begin
            s = 6'(e >> (6 * (n - 1 - k)));
            check({26'h0, bus_write, bus_word, bus_lock, bus_target}, {26'h0, s});
            check({8'h0, bus_addr}, {8'h0, addr_of(target_t'(s[2:0]))});
            k++;
         end
      end
      check(32'(k), 32'(n));
      check({31'h0, held}, {31'h0, s[3]});
      if (instr_done !== 1'b1) begin
         err_count++;
         finish_test();
      end
      $display("Test class %0d done", c);
   endtask

   // Reset state first, then every class once, some with prompt acks and some with slow ones
   initial begin
      repeat (20) @(negedge sys_clk);
      check({29'h0, instr_ready, bus_req, instr_done}, 32'h4);
      srst = 1'b0;
      run(CLS_SHORT, 1, {30'h0, RWN}, 4'h0);
      run(CLS_IMM16, 2, {24'h0, RW2, RWN}, 4'h3);
      run(CLS_IMM32, 3, {18'h0, RW2, RW3, RWN}, 4'h0);
      run(CLS_TWO_WORD, 2, {24'h0, RW2, RWN}, 4'h1);
      run(CLS_BTST_SHORT, 3, {18'h0, RW2, RBE, RWNM}, 4'h0);
      run(CLS_BTST_ABS16, 4, {12'h0, RW2, RW3, RBE, RWNM}, 4'h2);
      run(CLS_BTST_ABS32, 5, {6'h0, RW2, RW3, RW4, RBE, RWNM}, 4'h0);
      run(CLS_BRANCH8, 2, {24'h0, RWN, RWE}, 4'h0);
      run(CLS_BRANCH16, 2, {24'h0, RW2, RWE}, 4'h1);
      run(CLS_BIT_CLEAR_OP_REG, 1, {30'h0, RWN}, 4'h0);
      run(CLS_BIT_CLEAR_OP_SHORT, 4, {12'h0, RW2, RBEM, RWNM, WBE}, 4'h0);
      run(CLS_BIT_CLEAR_OP_ABS16, 5, {6'h0, RW2, RW3, RBEM, RWNM, WBE}, 4'h4);
      run(CLS_BIT_CLEAR_OP_ABS32, 6, {RW2, RW3, RW4, RBEM, RWNM, WBE}, 4'h0);
      finish_test();
   end
endmodule
